// >>> hw/pdt_pkg.sv
// constants shared by the prescaled down timer: register indices, field positions,
// reset values and mode encoding
// assumes a 32-bit classic wishbone bus with byte addresses, word aligned registers
package pdt_pkg;

  // bus geometry
  localparam int WB_DW = 32;
  localparam int WB_SW = 4;
  localparam int ADDR_W = 12;
  localparam int IDX_W = ADDR_W - 2;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PRESCALER = 10'h0D2;
  localparam logic [IDX_W-1:0] IDX_COUNTER = 10'h0D3;
  localparam logic [IDX_W-1:0] IDX_STATUS_CONTROL = 10'h0D4;
  localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 10'h0D5;
  localparam logic [IDX_W-1:0] IDX_EVT_MASK = 10'h0D6;

  // widths
  localparam int CNT_W = 8;
  localparam int PRE_W = 7;
  localparam int TAP_W = 3;
  localparam int EVT_W = 2;

  // timer_status_control field positions
  localparam int SC_ZERO_FLAG = 7;
  localparam int SC_IRQ_EN = 6;
  localparam int SC_PIN_DIR = 5;
  localparam int SC_PIN_DATA = 4;
  localparam int SC_RUN = 3;
  localparam int SC_TAP_LSB = 0;

  // event status / mask field positions
  localparam int EV_ZERO = 0;
  localparam int EV_PIN_RISE = 1;

  // values after reset
  localparam logic [CNT_W-1:0] COUNTER_RST = 8'hFF;
  localparam logic [PRE_W-1:0] PRESCALER_RST = 7'h7F;
  localparam logic [7:0] STATUS_CONTROL_RST = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RST = 2'h0;

  // internal clock division ahead of the prescaler
  localparam int CORE_DIV = 12;

  typedef enum logic [1:0] {
    MODE_EVENT,
    MODE_GATED,
    MODE_OUTPUT
  } pdt_mode_t;

endpackage

// >>> hw/pdt_prescaler.sv
// 7-bit down-counting prescaler with a selectable tap feeding the counter clock
// assumes preTick is a one-cycle enable already in the clock domain
`timescale 1ns/1ps
module pdt_prescaler #(
  parameter int PRE_W = 7,
  parameter int TAP_W = 3
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic preTick,
  input wire logic loadEn,
  input wire logic [PRE_W-1:0] loadVal,
  input wire logic [TAP_W-1:0] tapSel,
  output logic [PRE_W-1:0] value,
  output logic cntTick
);
  import pdt_pkg::*;

  logic [PRE_W-1:0] pre_ff;
  logic [PRE_W-1:0] nxt_pre;
  logic [PRE_W:0] riseVec;

  assign nxt_pre = pre_ff - PRE_W'(1);
  assign value = pre_ff;

  // factor 1 takes the prescaler input itself
  assign riseVec[0] = 1'b1;
  // factor 2^k takes the rising edge of bit k-1
  generate
    for (genvar k = 0; k < PRE_W; k++) begin : g_tap
      assign riseVec[k+1] = ~pre_ff[k] & nxt_pre[k];
    end
  endgenerate

  // a load swallows the tick so the loaded value is seen intact
  assign cntTick = run & preTick & ~loadEn & riseVec[tapSel];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pre_ff <= PRESCALER_RST;
    end else if (!run) begin
      pre_ff <= PRESCALER_RST;
    end else if (loadEn) begin
      pre_ff <= loadVal;
    end else if (preTick) begin
      pre_ff <= nxt_pre;
    end
  end

endmodule

// >>> hw/pdt_timer.sv
// prescaled 8-bit down timer with count pin, wishbone register access and interrupts
// assumes a classic wishbone master on the same clock; the count pin is asynchronous
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - counter drops by one per selected tap edge; software loads and reads it
// - a decrement reaching zero sets the zero-reached flag
// - timer request is high while the zero flag and its enable are both set
// - the timer request may wake the core out of wait
// - prescaler input is the internal clock over twelve or the count pin
// - prescaler is a 7-bit down-counter stepping on its input edge
// - tap select picks input clock for factor 1, else prescaler bit edges
// - run bit low forces prescaler to all ones and holds the counter
// - with run set, software may load any prescaler value up to 7Fh
// - gated mode steps from internal clock over twelve only while pin is high
// - event mode steps the prescaler on rising edges of the count pin
// - prescaler state is readable in its own register
// - tap codes 000 to 111 give factors 1 through 128
// - output mode uses internal clock; pin follows data while flag high, else latched
// - reset gives counter FFh, prescaler 7Fh, control register cleared
// - a counter write beats a simultaneous decrement to zero, flag stays clear
module pdt_timer #(
  parameter int CORE_DIV = pdt_pkg::CORE_DIV
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pdt_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [pdt_pkg::WB_SW-1:0] wb_sel_i,
  input wire logic [pdt_pkg::WB_DW-1:0] wb_dat_i,
  output logic [pdt_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic countPinIn,
  output logic countPinOut,
  output logic countPinOe,
  input wire logic coreWait,
  output logic timerIrqReq,
  output logic wakeReq,
  output logic irq
);
  import pdt_pkg::*;

  localparam int DIV_W = $clog2(CORE_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CORE_DIV - 1);

  // bus side
  logic ack_ff;
  logic [WB_DW-1:0] datOut_ff;
  logic [IDX_W-1:0] reqIdx;
  logic reqLive;
  logic accessNow;
  logic wrEn;
  logic rdEn;
  logic wrPrescaler;
  logic wrCounter;
  logic wrControl;
  logic wrEvtMask;
  logic rdEvtStatus;

  // control fields
  logic zeroFlag_ff;
  logic irqEnable_ff;
  logic pinDir_ff;
  logic pinData_ff;
  logic run_ff;
  logic [TAP_W-1:0] tap_ff;

  // counting
  logic [CNT_W-1:0] counter_ff;
  logic [PRE_W-1:0] prescalerValue;
  logic cntTick;
  logic preTick;
  logic hwZero;
  logic [DIV_W-1:0] div_ff;
  logic divTick;
  pdt_mode_t mode;

  // pin
  logic pinMeta_ff;
  logic pinSync_ff;
  logic pinLast_ff;
  logic pinRise;
  logic pinLatch_ff;

  // interrupt status
  logic [EVT_W-1:0] evtStatus_ff;
  logic [EVT_W-1:0] evtMask_ff;
  logic [EVT_W-1:0] evtSet;

  function automatic logic hitReg(
    input logic [IDX_W-1:0] idx,
    input logic [IDX_W-1:0] target
  );
    return idx == target;
  endfunction

  function automatic pdt_mode_t decodeMode(input logic dir, input logic data);
    pdt_mode_t m;
    m = MODE_OUTPUT;
    if (!dir) begin
      m = data ? MODE_GATED : MODE_EVENT;
    end
    return m;
  endfunction

  // unmapped indices read as zero
  function automatic logic [WB_DW-1:0] readMux(input logic [IDX_W-1:0] idx);
    logic [WB_DW-1:0] d;
    d = '0;
    if (hitReg(idx, IDX_PRESCALER)) begin
      d[PRE_W-1:0] = prescalerValue;
    end else if (hitReg(idx, IDX_COUNTER)) begin
      d[CNT_W-1:0] = counter_ff;
    end else if (hitReg(idx, IDX_STATUS_CONTROL)) begin
      d[SC_ZERO_FLAG] = zeroFlag_ff;
      d[SC_IRQ_EN] = irqEnable_ff;
      d[SC_PIN_DIR] = pinDir_ff;
      d[SC_PIN_DATA] = pinData_ff;
      d[SC_RUN] = run_ff;
      d[SC_TAP_LSB +: TAP_W] = tap_ff;
    end else if (hitReg(idx, IDX_EVT_STATUS)) begin
      d[EVT_W-1:0] = evtStatus_ff;
    end else if (hitReg(idx, IDX_EVT_MASK)) begin
      d[EVT_W-1:0] = evtMask_ff;
    end
    return d;
  endfunction

  // bus decode: effects happen on the edge that carries ack
  // sel[0] alone qualifies a write, as every register sits in the low byte
  assign reqIdx = wb_adr_i[ADDR_W-1:2];
  assign reqLive = wb_cyc_i & wb_stb_i;
  assign accessNow = reqLive & ack_ff;
  assign wrEn = accessNow & wb_we_i & wb_sel_i[0];
  assign rdEn = accessNow & ~wb_we_i;
  assign wrPrescaler = wrEn & hitReg(reqIdx, IDX_PRESCALER) & run_ff;
  assign wrCounter = wrEn & hitReg(reqIdx, IDX_COUNTER);
  assign wrControl = wrEn & hitReg(reqIdx, IDX_STATUS_CONTROL);
  assign wrEvtMask = wrEn & hitReg(reqIdx, IDX_EVT_MASK);
  assign rdEvtStatus = rdEn & hitReg(reqIdx, IDX_EVT_STATUS);

  // ack drops for a cycle after each access, so a held strobe is answered every second cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= reqLive & ~ack_ff;
    end
  end

  // read data captured on the same edge that raises ack so it is stable while ack is high
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      datOut_ff <= '0;
    end else if (reqLive & ~ack_ff & ~wb_we_i) begin
      datOut_ff <= readMux(reqIdx);
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = datOut_ff;

  // control register fields, one flop per field
  // run low also pins the prescaler at all ones, inside the prescaler
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqEnable_ff <= STATUS_CONTROL_RST[SC_IRQ_EN];
    end else if (wrControl) begin
      irqEnable_ff <= wb_dat_i[SC_IRQ_EN];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinDir_ff <= STATUS_CONTROL_RST[SC_PIN_DIR];
    end else if (wrControl) begin
      pinDir_ff <= wb_dat_i[SC_PIN_DIR];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinData_ff <= STATUS_CONTROL_RST[SC_PIN_DATA];
    end else if (wrControl) begin
      pinData_ff <= wb_dat_i[SC_PIN_DATA];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      run_ff <= STATUS_CONTROL_RST[SC_RUN];
    end else if (wrControl) begin
      run_ff <= wb_dat_i[SC_RUN];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tap_ff <= STATUS_CONTROL_RST[SC_TAP_LSB +: TAP_W];
    end else if (wrControl) begin
      tap_ff <= wb_dat_i[SC_TAP_LSB +: TAP_W];
    end
  end

  // a hardware zero wins over a software clear in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      zeroFlag_ff <= STATUS_CONTROL_RST[SC_ZERO_FLAG];
    end else if (hwZero) begin
      zeroFlag_ff <= 1'b1;
    end else if (wrControl) begin
      zeroFlag_ff <= wb_dat_i[SC_ZERO_FLAG];
    end
  end

  // internal clock divided by twelve, free running
  // run does not restart the divider, so the first step comes within twelve clocks
  assign divTick = (div_ff == DIV_LAST);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_ff <= '0;
    end else if (divTick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DIV_W'(1);
    end
  end

  // count pin passes two flops before anything looks at it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinMeta_ff <= 1'b0;
      pinSync_ff <= 1'b0;
    end else begin
      pinMeta_ff <= countPinIn;
      pinSync_ff <= pinMeta_ff;
    end
  end

  // edge history resets low like the idle pin, so reset leaves no false edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinLast_ff <= 1'b0;
    end else begin
      pinLast_ff <= pinSync_ff;
    end
  end

  assign pinRise = pinSync_ff & ~pinLast_ff;

  // prescaler input selection per mode
  // output mode never looks at the pin, so its own drive cannot step the prescaler
  assign mode = decodeMode(pinDir_ff, pinData_ff);

  always_comb begin
    preTick = 1'b0;
    unique case (mode)
      MODE_EVENT: begin
        preTick = pinRise;
      end
      MODE_GATED: begin
        preTick = divTick & pinSync_ff;
      end
      MODE_OUTPUT: begin
        preTick = divTick;
      end
    endcase
  end

  // the prescaler owns run, load and tap; it hands back one counter tick
  pdt_prescaler #(
    .PRE_W(PRE_W),
    .TAP_W(TAP_W)
  ) u_prescaler (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(run_ff),
    .preTick(preTick),
    .loadEn(wrPrescaler),
    .loadVal(wb_dat_i[PRE_W-1:0]),
    .tapSel(tap_ff),
    .value(prescalerValue),
    .cntTick(cntTick)
  );

  // zero is reached only by a real decrement that no write overrides
  assign hwZero = run_ff & cntTick & ~wrCounter & (counter_ff == 8'h01);

  // a stopped timer ignores ticks, but software writes land at any time
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      counter_ff <= COUNTER_RST;
    end else if (wrCounter) begin
      counter_ff <= wb_dat_i[CNT_W-1:0];
    end else if (run_ff & cntTick) begin
      // 00h wraps to FFh on the next tick
      counter_ff <= counter_ff - 8'h01;
    end
  end

  // output latch is transparent while the zero flag is high
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinLatch_ff <= 1'b0;
    end else if (zeroFlag_ff) begin
      pinLatch_ff <= pinData_ff;
    end
  end

  assign countPinOut = pinLatch_ff;
  assign countPinOe = pinDir_ff;

  // sticky events; read clears only what the read actually returned
  // an event landing in the clearing cycle stays pending
  assign evtSet[EV_ZERO] = hwZero;
  assign evtSet[EV_PIN_RISE] = pinRise & ~pinDir_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      evtStatus_ff <= EVT_RST;
    end else if (rdEvtStatus) begin
      evtStatus_ff <= evtSet | (evtStatus_ff & ~datOut_ff[EVT_W-1:0]);
    end else begin
      evtStatus_ff <= evtSet | evtStatus_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      evtMask_ff <= EVT_RST;
    end else if (wrEvtMask) begin
      evtMask_ff <= wb_dat_i[EVT_W-1:0];
    end
  end

  // irq serves the event registers; timerIrqReq is the flag and enable pair
  assign irq = |(evtStatus_ff & evtMask_ff);
  assign timerIrqReq = zeroFlag_ff & irqEnable_ff;
  // the core only listens to this while it sits in wait
  assign wakeReq = coreWait & timerIrqReq;

endmodule

// >>> sim/pdt_timer_sva.sv
// port checker for the prescaled down timer
// assumes one clock domain; bound to the timer from the bench top file
`timescale 1ns/1ps
module pdt_timer_sva (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pdt_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [pdt_pkg::WB_DW-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic countPinOe,
  input wire logic coreWait,
  input wire logic timerIrqReq,
  input wire logic wakeReq,
  input wire logic irq
);
  import pdt_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_wake_gate: assert property (wakeReq == (coreWait && timerIrqReq))
    else $error("wake request wrong");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !timerIrqReq && !countPinOe && !irq)
    else $error("outputs active after reset");
  a_psc_top_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[ADDR_W-1:2] == IDX_PRESCALER |-> wb_dat_o[31:7] == 25'h0)
    else $error("prescaler upper bits not zero");
  a_req_drop_sw: assert property ($fell(timerIrqReq) |-> $past(wb_ack_o && wb_we_i))
    else $error("timer request fell without a write");
  a_oe_by_write: assert property ($rose(countPinOe) |-> $past(wb_ack_o && wb_we_i))
    else $error("pin drive began without a write");
endmodule

// >>> sim/pdt_pin_model.sv
// count pin source and load for the prescaled down timer
// assumes callers run on clock edges; pin shows timer value only while driven
`timescale 1ns/1ps
module pdt_pin_model (
  input wire logic clock,
  input wire logic countPinOut,
  input wire logic countPinOe,
  output logic pinLevel
);
  logic srcLevel = 1'b0;
  assign pinLevel = countPinOe ? countPinOut : srcLevel;
  // pulses last several clocks so the two-flop sync never misses one
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock);
      srcLevel <= 1'b1;
      repeat (3) @(posedge clock);
      srcLevel <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  task automatic hold(input logic lvl, input int n);
    @(posedge clock);
    srcLevel <= lvl;
    repeat (n) @(posedge clock);
  endtask
endmodule

// >>> sim/pdt_timer_bench.sv
// self-checking bench for the prescaled down timer
// assumes the pin model as far side and a wishbone master driven here
`timescale 1ns/1ps
module pdt_timer_bench;
  import pdt_pkg::*;
  logic clock = 1'b0;
  logic sysRst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic coreWait = 1'b0;
  logic [WB_SW-1:0] sel = 4'hF;
  logic [ADDR_W-1:0] adr = 12'h000;
  logic [WB_DW-1:0] dat = 32'h0;
  logic [WB_DW-1:0] datO;
  logic ack, pin, pinOut, pinOe, tIrq, wake, irq;
  int nErrors = 0;
  int checks = 0;

  always #2.5 clock = ~clock;

  pdt_timer dut (.clock(clock), .sys_rst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO),
    .wb_ack_o(ack), .countPinIn(pin), .countPinOut(pinOut), .countPinOe(pinOe),
    .coreWait(coreWait), .timerIrqReq(tIrq), .wakeReq(wake), .irq(irq));
  pdt_pin_model pm (.clock(clock), .countPinOut(pinOut), .countPinOe(pinOe), .pinLevel(pin));

  task automatic cmp(input string what, input logic [WB_DW-1:0] e, input logic [WB_DW-1:0] g);
    checks++;
    if (g !== e) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] d,
    output logic [WB_DW-1:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    @(posedge clock);
    while (ack !== 1'b1) @(posedge clock);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    logic [WB_DW-1:0] q;
    xfer(1'b1, idx, d, q);
  endtask
  task automatic rdChk(input string what, input logic [IDX_W-1:0] idx, input logic [7:0] e);
    logic [WB_DW-1:0] q;
    xfer(1'b0, idx, 8'h00, q);
    cmp(what, {24'h0, e}, q);
  endtask

  task automatic sReset();
    rdChk("counter reset", IDX_COUNTER, 8'hFF);
    rdChk("prescaler reset", IDX_PRESCALER, 8'h7F);
    rdChk("control reset", IDX_STATUS_CONTROL, 8'h00);
    rdChk("mask reset", IDX_EVT_MASK, 8'h00);
    sel <= 4'hE;
    wr(IDX_EVT_MASK, 8'h03);
    sel <= 4'hF;
    rdChk("mask sel ignored", IDX_EVT_MASK, 8'h00);
    rdChk("unmapped", 10'h000, 8'h00);
  endtask
  task automatic sEvent();
    wr(IDX_COUNTER, 8'h03);
    wr(IDX_STATUS_CONTROL, 8'h08);
    pm.pulse(3);
    repeat (5) @(posedge clock);
    rdChk("counter zero", IDX_COUNTER, 8'h00);
    rdChk("prescaler steps", IDX_PRESCALER, 8'h7C);
    rdChk("zero flag", IDX_STATUS_CONTROL, 8'h88);
    rdChk("event status", IDX_EVT_STATUS, 8'h03);
    rdChk("status cleared", IDX_EVT_STATUS, 8'h00);
    pm.pulse(1);
    repeat (5) @(posedge clock);
    rdChk("counter wraps", IDX_COUNTER, 8'hFF);
  endtask
  task automatic sStop();
    wr(IDX_STATUS_CONTROL, 8'h00);
    rdChk("prescaler forced", IDX_PRESCALER, 8'h7F);
    wr(IDX_PRESCALER, 8'h10);
    rdChk("load refused", IDX_PRESCALER, 8'h7F);
    wr(IDX_COUNTER, 8'h40);
    pm.pulse(2);
    rdChk("counter held", IDX_COUNTER, 8'h40);
  endtask
  task automatic sTap();
    wr(IDX_STATUS_CONTROL, 8'h09);
    wr(IDX_PRESCALER, 8'h05);
    rdChk("prescaler load", IDX_PRESCALER, 8'h05);
    pm.pulse(4);
    repeat (5) @(posedge clock);
    rdChk("prescaler read", IDX_PRESCALER, 8'h01);
    rdChk("factor two", IDX_COUNTER, 8'h3E);
  endtask
  task automatic sOutput();
    int n;
    wr(IDX_EVT_MASK, 8'h01);
    wr(IDX_COUNTER, 8'h02);
    coreWait <= 1'b1;
    wr(IDX_STATUS_CONTROL, 8'h78);
    n = 0;
    while (tIrq !== 1'b1 && n < 60) begin
      @(posedge clock);
      n++;
    end
    cmp("twelve rate", 32'h1, {31'h0, n >= 10 && n <= 30});
    @(posedge clock);
    cmp("timer request", 32'h1, {31'h0, tIrq});
    cmp("wake", 32'h1, {31'h0, wake});
    cmp("irq", 32'h1, {31'h0, irq});
    cmp("pin driven", 32'h3, {30'h0, pinOe, pinOut});
    rdChk("status zero", IDX_EVT_STATUS, 8'h03);
    @(posedge clock);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    wr(IDX_STATUS_CONTROL, 8'h28);
    @(posedge clock);
    cmp("wake dropped", 32'h0, {31'h0, wake});
    cmp("pin latched", 32'h1, {31'h0, pinOut});
    coreWait <= 1'b0;
  endtask
  task automatic sGated();
    logic [WB_DW-1:0] q0, q1, q2;
    wr(IDX_STATUS_CONTROL, 8'h18);
    pm.hold(1'b0, 20);
    xfer(1'b0, IDX_COUNTER, 8'h00, q0);
    pm.hold(1'b0, 60);
    xfer(1'b0, IDX_COUNTER, 8'h00, q1);
    cmp("gate closed", q0, q1);
    pm.hold(1'b1, 60);
    xfer(1'b0, IDX_COUNTER, 8'h00, q2);
    cmp("gate open", 32'h1, {31'h0, q2[7:0] < q1[7:0]});
  endtask

  task automatic tallyAndFinish();
    $display("checks %0d errors %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock);
    sysRst <= 1'b0;
    sReset();
    sEvent();
    sStop();
    sTap();
    sOutput();
    sGated();
    tallyAndFinish();
  end
  initial begin
    repeat (20000) @(posedge clock);
    nErrors++;
    tallyAndFinish();
  end
endmodule

bind pdt_timer pdt_timer_sva chk (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .countPinOe(countPinOe), .coreWait(coreWait),
  .timerIrqReq(timerIrqReq), .wakeReq(wakeReq), .irq(irq));
